// file: hw/rcb_regs.vh
// Purpose: constants for the reset, clock boot and strap block
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes:   timing counts are module parameter defaults
`ifndef RCB_REGS_VH
`define RCB_REGS_VH

// ==========================================================
// timing
`define RCB_FILT_CYCLES   8
`define RCB_RESET_INDICATOR_OUT_CYCLES   1024
`define RCB_FILT_W        4
`define RCB_RESET_INDICATOR_OUT_W        11

// ==========================================================
// register offsets (byte addresses)
`define RCB_OFS_CTRL      8'h00
`define RCB_OFS_STATUS    8'h04
`define RCB_OFS_COUNT     8'h08
`define RCB_ADDR_W        8

// ==========================================================
// control fields
`define RCB_CTRL_SWRST    0

// ==========================================================
// status fields
`define RCB_ST_SEL_LO     0
`define RCB_ST_SEL_HI     1
`define RCB_ST_CRYSTAL_OUT_PIN       2
`define RCB_ST_PLL        3
`define RCB_ST_SRC_LO     4
`define RCB_ST_SRC_HI     5
`define RCB_ST_FLASH      6
`define RCB_ST_RSTACT     7
`define RCB_ST_RESET_INDICATOR_OUT       8

// ==========================================================
// clock boot select codes and clock sources
`define RCB_SEL_NOPLL_EXT 2'h0
`define RCB_SEL_NOPLL_XO  2'h1
`define RCB_SEL_PLL_EXT   2'h2
`define RCB_SEL_PLL_XO    2'h3
`define RCB_SRC_EXT       2'h0
`define RCB_SRC_ONCHIP    2'h1
`define RCB_SRC_CRYSTAL   2'h2

// ==========================================================
// ahb transfer type bit and response
`define RCB_HTRANS_ACT    1
`define RCB_HRESP_OKAY    1'h0

`endif

// file: hw/rcb_reset_boot.v
// Purpose: reset filter, reset indicator stretch, clock boot decode,
//          flash programming strap and system clock mirror
// Assumes: all pins synchronous to clk_sys; AHB-Lite single slave
// Notes:   boot straps are frozen at every reset release
//
// Functional notes
// - 8 low cycles of reset input reset core
// - indicator low 1024 cycles after release
// - select high bit: crystal pin becomes input
// - select 00: no PLL, external or on-chip
// - select 01: no PLL, crystal oscillator
// - select 10: PLL, external or on-chip
// - select 11: PLL from crystal oscillator
// - strap with test low enters flash programming
// - clock output follows system clock
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "rcb_regs.vh"

module rcb_reset_boot #(
    parameter FILT_CYCLES = `RCB_FILT_CYCLES,
    parameter RESET_INDICATOR_OUT_CYCLES = `RCB_RESET_INDICATOR_OUT_CYCLES
) (
    input  wire        clk_sys,               // cpu clock
    input  wire        rstn,                  // power-on reset, low
    input  wire        ext_reset_in_n,        // board reset, low
    output reg         reset_indicator_out_n, // stretched reset, low
    output wire        core_reset_n,          // cpu/periph reset, low
    input  wire [1:0]  clock_boot_select,     // boot select straps
    input  wire        crystal_out_pin_in,    // crystal pin level
    output wire        crystal_out_pin_out,   // crystal pin drive
    output wire        crystal_out_pin_oe,    // crystal pin enable
    input  wire        osc_in_pin,            // oscillator input
    output wire        system_clock_out,      // clock mirror
    input  wire        flash_program_strap,   // flash prog strap
    input  wire        test_pin,              // factory test pin
    output reg         serial_flash_port_en,  // flash prog mode
    output reg  [1:0]  boot_select_latched,   // frozen select
    output reg         pll_enable,            // pll normal mode
    output reg  [1:0]  clock_source,          // reference source
    input  wire        hsel,                  // ahb select
    input  wire [31:0] haddr,                 // ahb address
    input  wire [1:0]  htrans,                // ahb transfer type
    input  wire        hwrite,                // ahb write
    input  wire [2:0]  hsize,                 // ahb size
    input  wire [31:0] hwdata,                // ahb write data
    input  wire        hready,                // ahb bus ready
    output wire        hreadyout,             // ahb slave ready
    output wire        hresp,                 // ahb response
    output reg  [31:0] hrdata                 // ahb read data
);

// ==========================================================
// clock boot decode
// returns {pll_on, source[1:0]}
function [2:0] rcb_decode;
    input [1:0] sel;
    input       crystal_out_pin;
    begin
        case (sel)
            `RCB_SEL_NOPLL_EXT:
                rcb_decode = {1'b0, crystal_out_pin ? `RCB_SRC_ONCHIP
                                         : `RCB_SRC_EXT};
            `RCB_SEL_NOPLL_XO:
                rcb_decode = {1'b0, `RCB_SRC_CRYSTAL};
            `RCB_SEL_PLL_EXT:
                rcb_decode = {1'b1, crystal_out_pin ? `RCB_SRC_ONCHIP
                                         : `RCB_SRC_EXT};
            `RCB_SEL_PLL_XO:
                rcb_decode = {1'b1, `RCB_SRC_CRYSTAL};
            default:
                rcb_decode = {1'b0, `RCB_SRC_EXT};
        endcase
    end
endfunction

// crystal pin is driven only while the select high bit is 0
function rcb_pin_drives;
    input [1:0] sel;
    begin
        rcb_pin_drives = ~sel[1];
    end
endfunction

// counts are cut to the counter width on purpose
localparam integer FILT_LAST_I = FILT_CYCLES - 1;
localparam integer RESET_INDICATOR_OUT_LAST_I = RESET_INDICATOR_OUT_CYCLES - 1;
localparam [`RCB_FILT_W-1:0] FILT_LAST = FILT_LAST_I[`RCB_FILT_W-1:0];
localparam [`RCB_RESET_INDICATOR_OUT_W-1:0] RESET_INDICATOR_OUT_LAST = RESET_INDICATOR_OUT_LAST_I[`RCB_RESET_INDICATOR_OUT_W-1:0];

// ==========================================================
// state
reg  [`RCB_FILT_W-1:0] filt_cnt;
reg  [`RCB_RESET_INDICATOR_OUT_W-1:0] reset_indicator_out_cnt;
reg                    rst_active;
reg                    crystal_out_pin_latched;
reg                    soft_req;
reg                    wr_pend;
reg  [`RCB_ADDR_W-1:0] wr_addr;

reg  [`RCB_FILT_W-1:0] next_filt_cnt;
reg                    next_rst_active;
reg  [`RCB_RESET_INDICATOR_OUT_W-1:0] next_reset_indicator_out_cnt;
wire                   release_now;
wire [2:0]             mode_now;
wire                   addr_take;
wire [`RCB_ADDR_W-1:0] addr_lo;
reg  [31:0]            next_rdata;
wire [31:0]            ctrl_word;
wire [31:0]            status_word;
wire [31:0]            count_word;

// ==========================================================
// reset input filter
always @*
begin
    next_filt_cnt = filt_cnt;
    if (ext_reset_in_n)
        next_filt_cnt = {`RCB_FILT_W{1'b0}};
    else if (filt_cnt != FILT_LAST)
        next_filt_cnt = filt_cnt + 1'b1;
end

// short glitches on the reset pin never reach the core
always @*
begin
    next_rst_active = rst_active;
    if (soft_req)
        next_rst_active = 1'b1;
    else if (!ext_reset_in_n && filt_cnt == FILT_LAST)
        next_rst_active = 1'b1;
    else if (ext_reset_in_n)
        next_rst_active = 1'b0;
end

always @(posedge clk_sys or negedge rstn)
begin
    if (!rstn)
    begin
        filt_cnt   <= {`RCB_FILT_W{1'b0}};
        rst_active <= 1'b1;
    end
    else
    begin
        filt_cnt   <= next_filt_cnt;
        rst_active <= next_rst_active;
    end
end

assign core_reset_n = ~rst_active;

// ==========================================================
// reset indicator stretch
always @*
begin
    next_reset_indicator_out_cnt = reset_indicator_out_cnt;
    if (rst_active)
        next_reset_indicator_out_cnt = {`RCB_RESET_INDICATOR_OUT_W{1'b0}};
    else if (reset_indicator_out_cnt != RESET_INDICATOR_OUT_LAST)
        next_reset_indicator_out_cnt = reset_indicator_out_cnt + 1'b1;
end

always @(posedge clk_sys or negedge rstn)
begin
    if (!rstn)
    begin
        reset_indicator_out_cnt              <= {`RCB_RESET_INDICATOR_OUT_W{1'b0}};
        reset_indicator_out_n <= 1'b0;
    end
    else
    begin
        reset_indicator_out_cnt              <= next_reset_indicator_out_cnt;
        reset_indicator_out_n <= ~rst_active &&
                                 reset_indicator_out_cnt == RESET_INDICATOR_OUT_LAST;
    end
end

// ==========================================================
// boot strap capture
assign release_now = rst_active && !next_rst_active;
assign mode_now    = rcb_decode(clock_boot_select,
                                crystal_out_pin_in);

// captured by the clock, at release, never by the async reset
always @(posedge clk_sys or negedge rstn)
begin
    if (!rstn)
    begin
        boot_select_latched  <= 2'h0;
        crystal_out_pin_latched         <= 1'b0;
        pll_enable           <= 1'b0;
        clock_source         <= `RCB_SRC_EXT;
        serial_flash_port_en <= 1'b0;
    end
    else if (release_now)
    begin
        boot_select_latched  <= clock_boot_select;
        crystal_out_pin_latched         <= crystal_out_pin_in;
        pll_enable           <= mode_now[2];
        clock_source         <= mode_now[1:0];
        serial_flash_port_en <= flash_program_strap &&
                                !test_pin;
    end
end

// ==========================================================
// crystal pin and clock mirror
// during reset the live select decides, afterwards the frozen one
assign crystal_out_pin_oe  = rst_active
                           ? rcb_pin_drives(clock_boot_select)
                           : rcb_pin_drives(boot_select_latched);
assign crystal_out_pin_out = ~osc_in_pin;
// plain wire: gating here would glitch the mirror
assign system_clock_out    = clk_sys;

// ==========================================================
// ahb-lite slave, zero wait states
assign addr_take = hsel && hready && htrans[`RCB_HTRANS_ACT];
assign addr_lo   = haddr[`RCB_ADDR_W-1:0];
assign hreadyout = 1'b1;
assign hresp     = `RCB_HRESP_OKAY;

// ==========================================================
// read words, unused bits read zero
assign ctrl_word[`RCB_CTRL_SWRST] = soft_req;
assign ctrl_word[31:`RCB_CTRL_SWRST+1] = {(31-`RCB_CTRL_SWRST){1'b0}};

assign status_word[`RCB_ST_SEL_HI:`RCB_ST_SEL_LO] = boot_select_latched;
assign status_word[`RCB_ST_CRYSTAL_OUT_PIN]   = crystal_out_pin_latched;
assign status_word[`RCB_ST_PLL]    = pll_enable;
assign status_word[`RCB_ST_SRC_HI:`RCB_ST_SRC_LO] = clock_source;
assign status_word[`RCB_ST_FLASH]  = serial_flash_port_en;
assign status_word[`RCB_ST_RSTACT] = rst_active;
assign status_word[`RCB_ST_RESET_INDICATOR_OUT]   = reset_indicator_out_n;
assign status_word[31:`RCB_ST_RESET_INDICATOR_OUT+1] = {(31-`RCB_ST_RESET_INDICATOR_OUT){1'b0}};

// lets software watch the stretch count up
assign count_word = {{(32-`RCB_RESET_INDICATOR_OUT_W){1'b0}}, reset_indicator_out_cnt};

always @*
begin
    next_rdata = 32'h0000_0000;
    case (addr_lo)
        `RCB_OFS_CTRL:
            next_rdata = ctrl_word;
        `RCB_OFS_STATUS:
            next_rdata = status_word;
        `RCB_OFS_COUNT:
            next_rdata = count_word;
        default:
            next_rdata = 32'h0000_0000;
    endcase
end

always @(posedge clk_sys or negedge rstn)
begin
    if (!rstn)
    begin
        wr_pend <= 1'b0;
        wr_addr <= {`RCB_ADDR_W{1'b0}};
        hrdata  <= 32'h0000_0000;
    end
    else
    begin
        wr_pend <= addr_take && hwrite;
        if (addr_take)
            wr_addr <= addr_lo;
        if (addr_take && !hwrite)
            hrdata <= next_rdata;
    end
end

// software reset request: one pulse into the reset source
always @(posedge clk_sys or negedge rstn)
begin
    if (!rstn)
        soft_req <= 1'b0;
    else if (wr_pend && wr_addr == `RCB_OFS_CTRL)
        soft_req <= hwdata[`RCB_CTRL_SWRST];
    else
        soft_req <= 1'b0;
end

endmodule

// file: tb/rcb_board.sv
// Purpose: board supervisor and strap pins around the block
// Assumes: changes land just after rising clock edges
// Notes:   oscillator input is a static level, set per boot to the inverse of the crystal strap
`timescale 1ns/1ps
// ==========================================
// board model
module rcb_board (
    input              clk_sys,                    // clock
    input              crystal_out_pin_out,        // block drive
    input              crystal_out_pin_oe,         // block enable
    output logic       ext_reset_in_n = 1'b1,      // supervisor
    output logic [1:0] clock_boot_select = 2'h0,   // straps
    output wire        crystal_out_pin_in,         // pin level
    output logic       osc_in_pin = 1'b1,          // oscillator
    output logic       flash_program_strap = 1'b0, // strap
    output logic       test_pin = 1'b0             // set per boot
);
    logic crystal_out_pin_strap = 1'b0;
    // strap resistor only wins while the block lets go
    assign crystal_out_pin_in = crystal_out_pin_oe ? crystal_out_pin_out
                                                   : crystal_out_pin_strap;
    task automatic hold_reset(input int n, input logic [1:0] s,
                              input logic x, f, t);
        @(posedge clk_sys);
        ext_reset_in_n <= 1'b0;
        clock_boot_select <= s;
        crystal_out_pin_strap <= x;
        osc_in_pin <= ~x; // a driven pin then reads the strap too
        flash_program_strap <= f;
        test_pin <= t;
        repeat (n) @(posedge clk_sys);
        ext_reset_in_n <= 1'b1;
    endtask
endmodule

// file: tb/rcb_reset_boot_checker.sv
// Purpose: port assertions for the reset and boot block
// Assumes: bound into rcb_reset_boot
// Notes:   stretch length follows RESET_INDICATOR_OUT_CYCLES
`timescale 1ns/1ps
// ==========================================
// checker
module rcb_chk #(
    parameter FILT_CYCLES = 8,
    parameter RESET_INDICATOR_OUT_CYCLES = 1024
) (
    input       clk_sys,               // clock
    input       rstn,                  // reset
    input       ext_reset_in_n,        // board reset
    input       core_reset_n,          // core reset
    input       reset_indicator_out_n, // stretched
    input [1:0] clock_boot_select,     // straps
    input       crystal_out_pin_in,    // pin level
    input       crystal_out_pin_oe,    // pin enable
    input [1:0] boot_select_latched,   // frozen
    input       pll_enable,            // pll
    input [1:0] clock_source,          // source
    input       flash_program_strap,   // strap
    input       test_pin,              // test
    input       serial_flash_port_en   // flash mode
);
    logic [11:0] held;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // counts from core release so an early stretch end shows
    always @(posedge clk_sys or negedge rstn)
        if (!rstn)
            held <= 12'h000;
        else if (!core_reset_n)
            held <= 12'h000;
        else if (!reset_indicator_out_n)
            held <= held + 12'h001;
    a_filter_hit: assert property (
        !ext_reset_in_n [*8] |=> !core_reset_n) else $error("no reset");
    a_stretch_len: assert property (
        $rose(reset_indicator_out_n) |-> held == RESET_INDICATOR_OUT_CYCLES)
        else $error("stretch length wrong");
    a_stretch_low: assert property (
        !core_reset_n |=> !reset_indicator_out_n) else $error("early out");
    a_pll_mode: assert property (
        $rose(core_reset_n) |-> pll_enable == $past(clock_boot_select[1]))
        else $error("pll mode wrong");
    a_source_pick: assert property (
        $rose(core_reset_n) |-> clock_source == ($past(clock_boot_select[0])
        ? 2'h2 : {1'b0, $past(crystal_out_pin_in)})) else $error("source");
    a_crystal_out_pin_input: assert property (
        core_reset_n && boot_select_latched[1] |-> !crystal_out_pin_oe)
        else $error("crystal pin driven");
    a_flash_mode: assert property (
        $rose(core_reset_n) |-> serial_flash_port_en ==
        ($past(flash_program_strap) && !$past(test_pin))) else $error("flash");
    a_straps_held: assert property (
        core_reset_n && $past(core_reset_n) |-> $stable(boot_select_latched)
        && $stable(clock_source)) else $error("straps moved");
    c_stretch: cover property ($rose(reset_indicator_out_n));
    c_pll: cover property ($rose(core_reset_n) ##1 pll_enable);
    c_flash: cover property ($rose(serial_flash_port_en));
endmodule
bind rcb_reset_boot rcb_chk #(.FILT_CYCLES(FILT_CYCLES),
    .RESET_INDICATOR_OUT_CYCLES(RESET_INDICATOR_OUT_CYCLES)) chk_u (.*);

// file: tb/testbench.sv
// Purpose: self-checking bench for the reset and boot block
// Assumes: board model owns the reset input and straps
// Notes:   stretch shortened so the run stays brief
`timescale 1ns/1ps
// ==========================================
// bench
module testbench;
    localparam STRETCH = 16;
    logic        clk_sys;
    logic        rstn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    wire         ext_reset_in_n, crystal_out_pin_in, osc_in_pin, test_pin;
    wire         flash_program_strap, reset_indicator_out_n, core_reset_n;
    wire         crystal_out_pin_out, crystal_out_pin_oe, system_clock_out;
    wire         serial_flash_port_en, pll_enable, hreadyout, hresp;
    wire [1:0]   clock_boot_select, boot_select_latched, clock_source;
    wire [31:0]  hrdata;
    wire         hready = hreadyout;
    int          n_fail = 0, num_checks = 0;
    rcb_reset_boot #(.RESET_INDICATOR_OUT_CYCLES(STRETCH)) dut_u (.*);
    rcb_board brd_u (.*);
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge clk_sys);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic boot(input logic [1:0] s, input logic x, f, t);
        logic [1:0] src;
        src = s[0] ? 2'h2 : {1'b0, x};
        brd_u.hold_reset(8, s, x, f, t);
        #1 chk(core_reset_n, 1'b0);
        @(posedge clk_sys);
        #1 chk({boot_select_latched, pll_enable, clock_source,
            crystal_out_pin_oe, serial_flash_port_en, system_clock_out},
            {s, s[1], src, ~s[1], f & ~t, 1'b1});
        repeat (STRETCH - 1) @(posedge clk_sys);
        #1 chk(reset_indicator_out_n, 1'b0);
        @(posedge clk_sys);
        #1 chk(reset_indicator_out_n, 1'b1);
        brd_u.clock_boot_select <= ~s;
        bus(1'b0, 32'h04, 32'h0);
        chk(q, {23'h0, 2'h2, f & ~t, src, s[1], x, s});
        chk({hresp, crystal_out_pin_out}, {1'b0, x});
        $display("boot test done");
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        #100000;
        n_fail++;
        conclude;
    end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++)
            boot(i[1:0], i[2], i[0], i[2] & i[1]);
        brd_u.hold_reset(7, 2'h0, 1'b0, 1'b0, 1'b0);
        @(posedge clk_sys);
        #1 chk({core_reset_n, boot_select_latched}, 3'h7);
        $display("short reset test done");
        bus(1'b1, 32'h00, 32'h1);
        repeat (3) @(posedge clk_sys);
        #1 chk(reset_indicator_out_n, 1'b0);
        bus(1'b1, 32'h10, 32'hFFFFFFFF);
        bus(1'b0, 32'h10, 32'h0);
        chk(q, 32'h0);
        repeat (STRETCH) @(posedge clk_sys);
        #1 chk(reset_indicator_out_n, 1'b1);
        bus(1'b0, 32'h08, 32'h0);
        chk(q, STRETCH - 1);
        @(negedge clk_sys);
        #1 chk(system_clock_out, 1'b0);
        $display("bus test done");
        conclude;
    end
endmodule
